/* src/dpfl_pkg.sv */
// Package of constants for the dual-port fault and limit control block
package dpfl_pkg;
	// Strap code layout: bit 3 selects stand-alone, bits 2:0 the limit index
	localparam int STRAP_W        = 4;
	localparam int LIM_W          = 3;
	localparam int STRAP_MODE_BIT = 3;
	// Limit index of the highest setting that allows constant-current (1.6 A)
	localparam logic [2:0] CC_MAX_LIMIT = 3'h4;
	// Reset value of the programmed limit: highest index, clamped later
	localparam logic [2:0] LIMIT_RST = 3'h7;
	// Behaviour field reset value (alert on threshold)
	localparam logic [1:0] RATION_ALERT_BEHAVIOUR_RST = 2'h0;
	localparam logic [1:0] RATION_ALERT_BEHAVIOUR_ALERT = 2'h0;
	localparam logic [1:0] RATION_ALERT_BEHAVIOUR_LATCH = 2'h1;
	// Clock rate
	localparam int CLK_MHZ = 100;
	// Times in their own units
	localparam int SHORT_LIM_NS    = 200;
	localparam int RISE_TIME_US    = 1000;
	localparam int BOOST_HOLD_MS   = 2;
	localparam int RECOVERY_MS     = 20;
	localparam int PERSIST_NS      = 1000;
	// Derived cycle counts (least times round up)
	localparam int SHORT_LIM_CYC = (SHORT_LIM_NS * CLK_MHZ) / 1000;
	localparam int PERSIST_CYC   = (PERSIST_NS * CLK_MHZ + 999) / 1000;
	localparam int RISE_CYC      = RISE_TIME_US * CLK_MHZ;
	localparam int BOOST_CYC     = BOOST_HOLD_MS * 1000 * CLK_MHZ;
	localparam int RECOVERY_CYC  = RECOVERY_MS * 1000 * CLK_MHZ;
	localparam int CNT_W = 32;
	// Port states
	typedef enum logic [1:0] {
		DPFL_OFF    = 2'b00,
		DPFL_SOFT   = 2'b01,
		DPFL_ACTIVE = 2'b10,
		DPFL_ERROR  = 2'b11
	} dpfl_state_t;
endpackage : dpfl_pkg

/* src/dpfl_sync.sv */
`timescale 1ns/1ps
// Two-flop synchroniser for a vector of asynchronous inputs
module dpfl_sync #(
	parameter int W = 1
) (
	input  wire logic         clock_i,
	input  wire logic         rst_n_i,
	input  wire logic [W-1:0] async_i,
	output logic      [W-1:0] sync_o
);
	logic [W-1:0] meta_q;

	// First flop feeds only the second
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			meta_q <= '0;
			sync_o <= '0;
		end else begin
			meta_q <= async_i;
			sync_o <= meta_q;
		end
	end
endmodule : dpfl_sync

/* src/dpfl_port.sv */
`timescale 1ns/1ps
// Per-port state machine: soft start, limiting, error and recovery
module dpfl_port #(
	parameter int RISE_CYC     = dpfl_pkg::RISE_CYC,
	parameter int RECOVERY_CYC = dpfl_pkg::RECOVERY_CYC
) (
	input  wire logic       clock_i,
	input  wire logic       rst_n_i,
	input  wire logic       enable_i,
	input  wire logic       cc_allowed_i,
	input  wire logic       over_limit_i,
	input  wire logic       short_i,
	input  wire logic       discharging_i,
	output logic            switch_closed_o,
	output logic            current_limited_o,
	output logic            error_o
);
	dpfl_pkg::dpfl_state_t       state_q, state_d;
	logic [dpfl_pkg::CNT_W-1:0]  cnt_q, cnt_d;
	logic [dpfl_pkg::CNT_W-1:0]  short_q, short_d;
	wire                         short_persist;
	wire                         trip;

	// Short persisting past the response window becomes an error
	assign short_persist = short_q >= dpfl_pkg::CNT_W'(dpfl_pkg::PERSIST_CYC);
	// Trip mode opens at once; CC mode trips only when overcurrent persists
	assign trip = over_limit_i & (~cc_allowed_i | short_persist);

	always_comb begin
		state_d = state_q;
		cnt_d   = cnt_q;
		short_d = (short_i | over_limit_i) ? short_q + 1'b1 : '0;
		case (state_q)
			dpfl_pkg::DPFL_OFF: begin
				cnt_d = '0;
				if (enable_i) begin
					state_d = dpfl_pkg::DPFL_SOFT;
				end
			end
			dpfl_pkg::DPFL_SOFT: begin
				cnt_d = cnt_q + 1'b1;
				if (!enable_i) begin
					state_d = dpfl_pkg::DPFL_OFF;
				end else if (trip || short_persist) begin
					state_d = dpfl_pkg::DPFL_ERROR;
					cnt_d   = '0;
				end else if (cnt_q >= dpfl_pkg::CNT_W'(RISE_CYC - 1)) begin
					state_d = dpfl_pkg::DPFL_ACTIVE;
				end
			end
			dpfl_pkg::DPFL_ACTIVE: begin
				cnt_d = '0;
				if (trip || short_persist) begin
					state_d = dpfl_pkg::DPFL_ERROR;
				end else if (!enable_i) begin
					state_d = dpfl_pkg::DPFL_OFF;
				end
			end
			dpfl_pkg::DPFL_ERROR: begin
				// Auto-recovery after interval, only if causes cleared
				if (cnt_q >= dpfl_pkg::CNT_W'(RECOVERY_CYC - 1)) begin
					if (!over_limit_i && !short_i) begin
						state_d = enable_i ? dpfl_pkg::DPFL_ACTIVE
						                   : dpfl_pkg::DPFL_OFF;
					end
					cnt_d = '0;
				end else begin
					cnt_d = cnt_q + 1'b1;
				end
			end
			default: begin
				state_d = dpfl_pkg::DPFL_OFF;
			end
		endcase
	end

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_q <= dpfl_pkg::DPFL_OFF;
			cnt_q   <= '0;
			short_q <= '0;
		end else begin
			state_q <= state_d;
			cnt_q   <= cnt_d;
			short_q <= short_d;
		end
	end

	// Switch closed in soft start and Active unless discharging
	assign switch_closed_o   = ((state_q == dpfl_pkg::DPFL_ACTIVE) ||
	                            (state_q == dpfl_pkg::DPFL_SOFT)) &&
	                           !discharging_i;
	// Limiting only while closed: in soft start, on a short, or on overcurrent with CC allowed
	assign current_limited_o = switch_closed_o &
	                           ((state_q == dpfl_pkg::DPFL_SOFT) | short_i |
	                            (over_limit_i & cc_allowed_i));
	assign error_o           = state_q == dpfl_pkg::DPFL_ERROR;
endmodule : dpfl_port

/* src/dpfl_top.sv */
// Local design decisions: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
// Top of the dual-port fault and limit control block with register port

// Function
// - Separate fault alert per port
// - Alert is active-low open-drain on error
// - Rationing threshold asserts alert per behaviour field
// - Alert released only after all causes clear
// - Tolerate shared request and alert pin; in management mode own alert holds port off unless ignore-pins set
// - High-load output low above boost threshold
// - High-load is OR of both ports
// - High-load held for minimum assertion time
// - Strap sampled once at power-up
// - Eight hardware limits, same both ports
// - Strap selects mode and enable polarity
// - Programmed limit clamped to hardware limit
// - Switch closed in Active except discharging
// - Short limited quickly, persisting short errors
// - Soft start on enable for rise time
// - Trip and constant-current limiting while closed
// - Trip opens switch, Error, alert asserted
// - One limit value per port
// - Error keeps switch open, auto-recovers
// - Ignore-pins bit or software enables combined
// - Constant-current only at 1.6 A or below
module dpfl_top #(
	parameter int RISE_CYC     = dpfl_pkg::RISE_CYC,
	parameter int RECOVERY_CYC = dpfl_pkg::RECOVERY_CYC,
	parameter int BOOST_CYC    = dpfl_pkg::BOOST_CYC
) (
	input  wire logic       clock_i,
	input  wire logic       rst_n_i,
	input  wire logic [3:0] mode_limit_strap_i,
	input  wire logic       port1_power_request_i,
	input  wire logic       port2_power_request_i,
	input  wire logic [1:0] over_limit_i,
	input  wire logic [1:0] short_i,
	input  wire logic [1:0] boost_cmp_i,
	input  wire logic [1:0] ration_hit_i,
	input  wire logic [1:0] discharging_i,
	input  wire logic [2:0] reg_addr_i,
	input  wire logic [7:0] reg_wdata_i,
	input  wire logic       reg_wr_i,
	input  wire logic       reg_rd_i,
	output logic      [7:0] reg_rdata_o,
	output logic      [1:0] port_alert_n_o,
	output logic      [1:0] port_alert_oe_n_o,
	output logic            high_load_n_o,
	output logic            high_load_oe_n_o,
	output logic      [1:0] switch_closed_o,
	output logic      [1:0] current_limited_o,
	output logic      [2:0] active_limit_o,
	output logic            mgmt_mode_o
);
	// Register offsets
	localparam logic [2:0] ADDR_CTRL   = 3'h0;
	localparam logic [2:0] ADDR_LIMIT  = 3'h1;
	localparam logic [2:0] ADDR_STATUS = 3'h2;
	localparam logic [2:0] ADDR_STRAP  = 3'h3;
	localparam logic [2:0] ADDR_RCLR   = 3'h4;
	// Edges the synchroniser needs before the strap pin is valid
	localparam logic [1:0] STRAP_SETTLE = 2'h2;
	// Width of the boost hold counter
	localparam int BOOST_W = (BOOST_CYC > 1 ? $clog2(BOOST_CYC + 1) : 1) + 1;

	logic [3:0] strap_s;
	logic [1:0] req_s;
	logic [1:0] over_s;
	logic [1:0] short_s;
	logic [1:0] boost_s;
	logic [1:0] ration_s;
	logic [1:0] dis_s;
	logic       strap_done_q;
	logic [1:0] strap_wait_q;
	logic [3:0] strap_q;
	logic       ignore_pins_q;
	logic [1:0] soft_req_q;
	logic [1:0] ration_alert_behaviour_q;
	logic [2:0] limit_prog_q;
	logic [1:0] ration_flag_q;
	logic [BOOST_W-1:0] boost_cnt_q;
	logic       boost_q;
	logic [7:0] rdata_q;
	logic [1:0] port_err;
	logic [1:0] port_closed;
	logic [1:0] port_lim;
	logic [1:0] port_req_pin;
	logic [1:0] port_en;
	logic [2:0] hw_limit;
	wire        cc_ok;
	wire        any_boost;
	wire        wr_ctrl;
	wire        wr_limit;
	wire        wr_rclr;
	wire  [7:0] status;

	// Synchronise every pin and comparator input
	dpfl_sync #(.W(16)) u_sync (
		.clock_i (clock_i),
		.rst_n_i (rst_n_i),
		.async_i ({mode_limit_strap_i, port2_power_request_i, port1_power_request_i,
		           over_limit_i, short_i, boost_cmp_i, ration_hit_i, discharging_i}),
		.sync_o  ({strap_s, req_s, over_s, short_s, boost_s, ration_s, dis_s})
	);

	// Strap caught once the synchroniser holds the pin, then frozen
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			strap_done_q <= 1'b0;
			strap_wait_q <= 2'h0;
			strap_q      <= '0;
		end else if (!strap_done_q) begin
			if (strap_wait_q == STRAP_SETTLE) begin
				strap_done_q <= 1'b1;
				strap_q      <= strap_s;
			end else begin
				strap_wait_q <= strap_wait_q + 2'h1;
			end
		end
	end

	// Mode and polarity from strap bit 3; limit index from low bits
	assign mgmt_mode_o = ~strap_q[dpfl_pkg::STRAP_MODE_BIT];
	assign hw_limit    = strap_q[dpfl_pkg::LIM_W-1:0];
	// Single effective limit, clamped to the strap value
	assign active_limit_o = (mgmt_mode_o && limit_prog_q < hw_limit) ? limit_prog_q
	                                                                 : hw_limit;
	assign cc_ok = active_limit_o <= dpfl_pkg::CC_MAX_LIMIT;

	// Register write decode
	assign wr_ctrl  = reg_wr_i && reg_addr_i == ADDR_CTRL;
	assign wr_limit = reg_wr_i && reg_addr_i == ADDR_LIMIT;
	assign wr_rclr  = reg_wr_i && reg_addr_i == ADDR_RCLR;

	// Control and limit registers
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ignore_pins_q <= 1'b0;
			soft_req_q    <= 2'h0;
			ration_alert_behaviour_q  <= dpfl_pkg::RATION_ALERT_BEHAVIOUR_RST;
			limit_prog_q  <= dpfl_pkg::LIMIT_RST;
		end else begin
			if (wr_ctrl) begin
				soft_req_q    <= reg_wdata_i[1:0];
				ignore_pins_q <= reg_wdata_i[2];
				ration_alert_behaviour_q  <= reg_wdata_i[5:4];
			end
			if (wr_limit) begin
				limit_prog_q <= reg_wdata_i[2:0];
			end
		end
	end

	// Per-port enable and alert logic
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_port
			// Polarity follows the mode; in management mode the shared pin sees own alert low as idle
			assign port_req_pin[gi] = mgmt_mode_o ? req_s[gi] : ~req_s[gi];
			// Shared pin: alert low only on error or rationing; in management mode the port is held off then unless the ignore-pins bit is set
			assign port_en[gi] = strap_done_q & (mgmt_mode_o ?
			                     (ignore_pins_q ? soft_req_q[gi]
			                                    : soft_req_q[gi] & port_req_pin[gi])
			                     : port_req_pin[gi]);

			dpfl_port #(
				.RISE_CYC     (RISE_CYC),
				.RECOVERY_CYC (RECOVERY_CYC)
			) u_port (
				.clock_i           (clock_i),
				.rst_n_i           (rst_n_i),
				.enable_i          (port_en[gi]),
				.cc_allowed_i      (cc_ok),
				.over_limit_i      (over_s[gi]),
				.short_i           (short_s[gi]),
				.discharging_i     (dis_s[gi]),
				.switch_closed_o   (port_closed[gi]),
				.current_limited_o (port_lim[gi]),
				.error_o           (port_err[gi])
			);

			// Rationing flag: set wins over clear
			always_ff @(posedge clock_i or negedge rst_n_i) begin
				if (!rst_n_i) begin
					ration_flag_q[gi] <= 1'b0;
				end else if (ration_s[gi] &&
				             (ration_alert_behaviour_q == dpfl_pkg::RATION_ALERT_BEHAVIOUR_ALERT ||
				              ration_alert_behaviour_q == dpfl_pkg::RATION_ALERT_BEHAVIOUR_LATCH)) begin
					ration_flag_q[gi] <= 1'b1;
				end else if (wr_rclr && reg_wdata_i[gi]) begin
					ration_flag_q[gi] <= 1'b0;
				end
			end

			// Open-drain alert: pull low while any cause remains
			assign port_alert_n_o[gi]    = 1'b0;
			assign port_alert_oe_n_o[gi] = ~(port_err[gi] | ration_flag_q[gi]);
		end
	endgenerate

	assign switch_closed_o   = port_closed;
	assign current_limited_o = port_lim;

	// High-load output: OR of ports with minimum hold
	assign any_boost = boost_s[0] | boost_s[1];
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			boost_q     <= 1'b0;
			boost_cnt_q <= '0;
		end else if (any_boost) begin
			boost_q     <= 1'b1;
			boost_cnt_q <= '0;
		end else if (boost_q) begin
			if (boost_cnt_q >= BOOST_W'(BOOST_CYC - 1)) begin
				boost_q <= 1'b0;
			end else begin
				boost_cnt_q <= boost_cnt_q + 1'b1;
			end
		end
	end
	assign high_load_n_o    = 1'b0;
	assign high_load_oe_n_o = ~boost_q;

	// Status word
	assign status = {boost_q, ration_flag_q, port_lim, port_err, mgmt_mode_o};

	// Read data one cycle after strobe; unmapped reads zero
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rdata_q <= 8'h00;
		end else if (reg_rd_i) begin
			case (reg_addr_i)
				ADDR_CTRL:   rdata_q <= {2'h0, ration_alert_behaviour_q, 1'b0, ignore_pins_q, soft_req_q};
				ADDR_LIMIT:  rdata_q <= {5'h00, active_limit_o};
				ADDR_STATUS: rdata_q <= status;
				ADDR_STRAP:  rdata_q <= {4'h0, strap_q};
				default:     rdata_q <= 8'h00;
			endcase
		end else begin
			rdata_q <= 8'h00;
		end
	end
	assign reg_rdata_o = rdata_q;
endmodule : dpfl_top

/* tb/dpfl_chk.sv */
// Checker of port timing for the fault and limit control block
`timescale 1ns/1ps
module dpfl_chk #(
	parameter int BOOST_CYC = 30
) (
	input wire logic       clock_i,
	input wire logic       rst_n_i,
	input wire logic [1:0] over_limit_i,
	input wire logic [1:0] boost_cmp_i,
	input wire logic [1:0] port_alert_n_o,
	input wire logic [1:0] port_alert_oe_n_o,
	input wire logic       high_load_n_o,
	input wire logic       high_load_oe_n_o,
	input wire logic [1:0] switch_closed_o,
	input wire logic [1:0] current_limited_o,
	input wire logic [2:0] active_limit_o,
	input wire logic       mgmt_mode_o
);
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!rst_n_i);
	logic [31:0] low_q;
	logic [3:0]  up_q;
	// Length of a boost assertion; cycles since reset, saturating
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			low_q <= 32'h0;
			up_q  <= 4'h0;
		end else begin
			low_q <= high_load_oe_n_o ? 32'h0 : low_q + 32'h1;
			up_q  <= (up_q == 4'hF) ? up_q : up_q + 4'h1;
		end
	end
	property p_alert_drive;
		port_alert_n_o == 2'h0;
	endproperty
	a_alert_drive: assert property (p_alert_drive)
		else $error("alert data not low");
	property p_hl_drive;
		high_load_n_o == 1'b0;
	endproperty
	a_hl_drive: assert property (p_hl_drive)
		else $error("high-load data not low");
	property p_hl_rise;
		|boost_cmp_i |-> ##[1:4] !high_load_oe_n_o;
	endproperty
	a_hl_rise: assert property (p_hl_rise)
		else $error("high-load not asserted");
	property p_hl_hold;
		$rose(high_load_oe_n_o) |-> low_q >= BOOST_CYC;
	endproperty
	a_hl_hold: assert property (p_hl_hold)
		else $error("high-load released early");
	property p_sync;
		$rose(over_limit_i[0]) && switch_closed_o[0] |=> switch_closed_o[0];
	endproperty
	a_sync: assert property (p_sync)
		else $error("comparator used unsynchronised");
	property p_trip;
		$fell(switch_closed_o[0]) && over_limit_i[0] && active_limit_o > 3'h4
			|-> ##[0:2] !port_alert_oe_n_o[0];
	endproperty
	a_trip: assert property (p_trip)
		else $error("trip without alert");
	property p_cc;
		(active_limit_o > 3'h4 && over_limit_i[0]) [*4] |-> !switch_closed_o[0];
	endproperty
	a_cc: assert property (p_cc)
		else $error("no trip above constant-current range");
	property p_strap;
		up_q == 4'hF |-> $stable(mgmt_mode_o) && (mgmt_mode_o || $stable(active_limit_o));
	endproperty
	a_strap: assert property (p_strap)
		else $error("strap decode changed");
	// Main scenarios
	c_boost: cover property (!high_load_oe_n_o);
	c_alert: cover property (!port_alert_oe_n_o[0]);
	c_limit: cover property (|current_limited_o);
endmodule : dpfl_chk

/* tb/dpfl_hub_model.sv */
// Hub controller model driving the power request pins
`timescale 1ns/1ps
module dpfl_hub_model (
	input  wire logic       active_low_i,
	input  wire logic [1:0] req_on_i,
	input  wire logic [1:0] alert_n_i,
	input  wire logic [1:0] alert_oe_n_i,
	output logic      [1:0] request_o
);
	logic [1:0] level;
	// Pin level the hub wants for each request
	assign level = active_low_i ? ~req_on_i : req_on_i;
	// Port one has a push-pull request pin
	assign request_o[0] = level[0];
	// Port two shares one pulled-up wire with its alert
	assign request_o[1] = level[1] & (alert_oe_n_i[1] | alert_n_i[1]);
	// Bus clock and data pins absent, nothing to ground
endmodule : dpfl_hub_model

/* tb/dpfl_top_tb_top.sv */
// Testbench of the dual-port fault and limit control block
`timescale 1ns/1ps
module dpfl_top_tb_top;
	localparam int RC = 20;
	localparam int RV = 50;
	localparam int BC = 30;
	logic       clock_i, rst_n_i, wr, rd, alow, hl_n, hl_oe_n, mgmt;
	logic [3:0] strap;
	logic [1:0] req_on, req, ovl, shrt, bst, rat, dis, a_n, a_oe_n, sw, lim;
	logic [2:0] addr, act;
	logic [7:0] wdata, rdata;
	int         failures, check_count;
	dpfl_top #(.RISE_CYC(RC), .RECOVERY_CYC(RV), .BOOST_CYC(BC)) dut (
		.clock_i(clock_i), .rst_n_i(rst_n_i), .mode_limit_strap_i(strap),
		.port1_power_request_i(req[0]), .port2_power_request_i(req[1]),
		.over_limit_i(ovl), .short_i(shrt), .boost_cmp_i(bst), .ration_hit_i(rat),
		.discharging_i(dis), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr),
		.reg_rd_i(rd), .reg_rdata_o(rdata), .port_alert_n_o(a_n),
		.port_alert_oe_n_o(a_oe_n), .high_load_n_o(hl_n), .high_load_oe_n_o(hl_oe_n),
		.switch_closed_o(sw), .current_limited_o(lim), .active_limit_o(act),
		.mgmt_mode_o(mgmt)
	);
	dpfl_hub_model hub (.active_low_i(alow), .req_on_i(req_on), .alert_n_i(a_n),
		.alert_oe_n_i(a_oe_n), .request_o(req));
	// Clock
	initial begin
		clock_i = 1'b0;
		forever #5 clock_i = ~clock_i;
	end
	task automatic cyc(input int n);
		repeat (n) @(posedge clock_i);
		#1;
	endtask : cyc
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			failures++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
		@(posedge clock_i);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge clock_i);
		wr <= 1'b0;
	endtask : wr_reg
	task automatic rd_reg(input logic [2:0] a, input logic [7:0] e);
		@(posedge clock_i);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clock_i);
		rd <= 1'b0;
		#1;
		chk(rdata, e);
	endtask : rd_reg
	task automatic reset(input logic [3:0] s);
		@(posedge clock_i);
		strap   <= s;
		rst_n_i <= 1'b0;
		repeat (8) @(posedge clock_i);
		rst_n_i <= 1'b1;
		cyc(10);
	endtask : reset
	task automatic end_of_test;
		if (failures == 0 && check_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : end_of_test
	// Watchdog
	initial begin
		#200000;
		failures++;
		end_of_test();
	end
	// Main sequence
	initial begin
		{rst_n_i, wr, rd, alow, strap, req_on, ovl, shrt, bst, rat, dis, addr, wdata} = '0;
		reset(4'h6);
		chk({7'h0, mgmt}, 8'h01);
		chk({5'h0, act}, 8'h06);
		rd_reg(3'h3, 8'h06);
		rd_reg(3'h7, 8'h00);
		@(posedge clock_i);
		strap <= 4'hB;
		cyc(8);
		chk({7'h0, mgmt}, 8'h01);
		chk({5'h0, act}, 8'h06);
		wr_reg(3'h1, 8'h07);
		rd_reg(3'h1, 8'h06);
		wr_reg(3'h1, 8'h02);
		rd_reg(3'h1, 8'h02);
		chk({5'h0, act}, 8'h02);
		wr_reg(3'h1, 8'h06);
		// Software bits combined with pins, then pins ignored
		@(posedge clock_i);
		req_on <= 2'h3;
		wr_reg(3'h0, 8'h02);
		cyc(RC + 10);
		chk({6'h0, sw}, 8'h02);
		wr_reg(3'h0, 8'h03);
		cyc(5);
		chk({6'h0, lim}, 8'h01);
		cyc(RC + 5);
		chk({6'h0, sw}, 8'h03);
		chk({6'h0, lim}, 8'h00);
		wr_reg(3'h0, 8'h07);
		@(posedge clock_i);
		req_on <= 2'h2;
		cyc(RC + 10);
		chk({6'h0, sw}, 8'h03);
		wr_reg(3'h0, 8'h03);
		cyc(5);
		chk({6'h0, sw}, 8'h02);
		@(posedge clock_i);
		req_on <= 2'h3;
		cyc(RC + 10);
		// Trip on port one, then recovery
		@(posedge clock_i);
		ovl <= 2'h1;
		cyc(10);
		chk({6'h0, sw}, 8'h02);
		chk({6'h0, a_oe_n}, 8'h02);
		@(posedge clock_i);
		ovl <= 2'h0;
		cyc(RV / 2);
		chk({6'h0, a_oe_n}, 8'h02);
		cyc(RV + RC + 20);
		chk({6'h0, sw}, 8'h03);
		chk({6'h0, a_oe_n}, 8'h03);
		// Constant current, then a lasting short
		wr_reg(3'h1, 8'h03);
		@(posedge clock_i);
		ovl <= 2'h1;
		cyc(20);
		chk({6'h0, lim}, 8'h01);
		chk({6'h0, sw}, 8'h03);
		@(posedge clock_i);
		ovl  <= 2'h0;
		shrt <= 2'h1;
		cyc(10);
		chk({6'h0, lim}, 8'h01);
		cyc(140);
		chk({6'h0, sw}, 8'h02);
		chk({6'h0, a_oe_n}, 8'h02);
		@(posedge clock_i);
		shrt <= 2'h0;
		cyc(RV + RC + 20);
		@(posedge clock_i);
		dis <= 2'h1;
		cyc(5);
		chk({6'h0, sw}, 8'h02);
		@(posedge clock_i);
		dis <= 2'h0;
		cyc(RC + 10);
		chk({6'h0, sw}, 8'h03);
		// High-load from either port, held after the cause falls
		for (int p = 1; p < 3; p++) begin
			@(posedge clock_i);
			bst <= p[1:0];
			cyc(5);
			chk({7'h0, hl_oe_n}, 8'h00);
			@(posedge clock_i);
			bst <= 2'h0;
			cyc(BC - 2);
			chk({7'h0, hl_oe_n}, 8'h00);
			cyc(10);
			chk({7'h0, hl_oe_n}, 8'h01);
		end
		// Rationing alert on port two for each behaviour
		for (int b = 0; b < 4; b++) begin
			wr_reg(3'h0, {2'h0, b[1:0], 4'h3});
			@(posedge clock_i);
			rat <= 2'h2;
			cyc(5);
			@(posedge clock_i);
			rat <= 2'h0;
			cyc(20);
			chk({6'h0, a_oe_n}, (b < 2) ? 8'h01 : 8'h03);
			chk({6'h0, sw}, (b < 2) ? 8'h01 : 8'h03);
			wr_reg(3'h4, 8'h02);
			cyc(5);
			chk({6'h0, a_oe_n}, 8'h03);
			cyc(RC + 20);
			chk({6'h0, sw}, 8'h03);
		end
		// Stand-alone strap with active-low requests
		@(posedge clock_i);
		req_on <= 2'h0;
		alow   <= 1'b1;
		reset(4'hD);
		chk({7'h0, mgmt}, 8'h00);
		chk({5'h0, act}, 8'h05);
		wr_reg(3'h1, 8'h01);
		cyc(3);
		chk({5'h0, act}, 8'h05);
		chk({6'h0, sw}, 8'h00);
		@(posedge clock_i);
		req_on <= 2'h1;
		cyc(RC + 10);
		chk({6'h0, sw}, 8'h01);
		end_of_test();
	end
endmodule : dpfl_top_tb_top
bind dpfl_top dpfl_chk #(.BOOST_CYC(BOOST_CYC)) u_chk (
	.clock_i(clock_i), .rst_n_i(rst_n_i), .over_limit_i(over_limit_i),
	.boost_cmp_i(boost_cmp_i), .port_alert_n_o(port_alert_n_o),
	.port_alert_oe_n_o(port_alert_oe_n_o), .high_load_n_o(high_load_n_o),
	.high_load_oe_n_o(high_load_oe_n_o), .switch_closed_o(switch_closed_o),
	.current_limited_o(current_limited_o), .active_limit_o(active_limit_o),
	.mgmt_mode_o(mgmt_mode_o)
);
